// >>> src/btc_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "btc_defs.svh"

// Function
// - skip-if-clear test skips next instruction only when selected bit is zero
// - skip-if-set test skips next instruction only when selected bit is one
// - a skip discards the prefetched instruction, runs a nop, two cycles
// - both calls push program counter plus one and take two cycles
// - immediate call: low byte from address field, high three from page buffer
// - indirect call: high three from table high pointer, low byte from accumulator
// - return address goes to entry at stack pointer, pointer then increments
// - register operand up to 127, bit select 0..7, 8-bit call address
module btc_exec #(
    parameter int STACK_DEPTH = 8,
    parameter int SP_W = $clog2(STACK_DEPTH)
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire btc_pkg::btc_op_t instr_op,
    input wire logic [`BTC_REG_W-1:0] reg_operand,
    input wire logic [`BTC_BIT_W-1:0] bit_sel,
    input wire logic [`BTC_ADR_W-1:0] call_addr,
    input wire logic [`BTC_DATA_W-1:0] reg_rdata,
    input wire logic [`BTC_PC_W-1:0] pc,
    input wire logic [`BTC_DATA_W-1:0] call_page_buffer,
    input wire logic [`BTC_DATA_W-1:0] table_high_pointer,
    input wire logic [`BTC_DATA_W-1:0] accumulator,
    output logic instr_ready,
    output logic [`BTC_REG_W-1:0] reg_raddr,
    output logic discard_r,
    output logic pc_load_r,
    output logic [`BTC_PC_W-1:0] pc_target_r,
    output logic [SP_W-1:0] stack_ptr_r,
    output logic [`BTC_PC_W-1:0] stack_top,
    output logic status_we
);

    // =================================================================
    // decode
    btc_pkg::btc_state_t state_r;
    logic accept;
    logic is_call;
    logic is_skip_op;
    logic bit_val;
    logic skip_take;
    logic [`BTC_PC_W-1:0] ret_addr;
    logic [`BTC_PC_W-1:0] target_nxt;

    // join a page value and a low byte into a program counter
    function automatic logic [`BTC_PC_W-1:0] btc_join(
        input logic [`BTC_DATA_W-1:0] page,
        input logic [`BTC_DATA_W-1:0] low
    );
        btc_join = {page[`BTC_PC_HI_MSB:0], low};
    endfunction : btc_join

    // a new instruction only enters while no extra cycle is running
    assign instr_ready = (state_r == btc_pkg::BTC_ST_IDLE);
    assign accept = instr_valid && instr_ready;
    assign reg_raddr = reg_operand;
    assign bit_val = reg_rdata[bit_sel];
    assign is_call = (instr_op == btc_pkg::BTC_OP_CALL) || (instr_op == btc_pkg::BTC_OP_ICALL);
    assign is_skip_op = (instr_op == btc_pkg::BTC_OP_SKIP_CLR) || (instr_op == btc_pkg::BTC_OP_SKIP_SET);
    assign skip_take = ((instr_op == btc_pkg::BTC_OP_SKIP_CLR) && !bit_val)
        || ((instr_op == btc_pkg::BTC_OP_SKIP_SET) && bit_val);
    // return address is the following instruction
    assign ret_addr = pc + `BTC_PC_INC;
    assign status_we = 1'b0;

    always_comb
    begin
        if (instr_op == btc_pkg::BTC_OP_ICALL)
        begin
            target_nxt = btc_join(table_high_pointer, accumulator);
        end
        else
        begin
            target_nxt = btc_join(call_page_buffer, call_addr);
        end
    end

    // =================================================================
    // sequencing: one extra cycle for a taken skip or a call
    // two-cycle skip
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= btc_pkg::BTC_ST_IDLE;
        end
        else
        begin
            unique case (state_r)
                btc_pkg::BTC_ST_IDLE:
                begin
                    if (accept && is_call)
                    begin
                        state_r <= btc_pkg::BTC_ST_CALL;
                    end
                    else if (accept && skip_take)
                    begin
                        state_r <= btc_pkg::BTC_ST_SKIP;
                    end
                end
                btc_pkg::BTC_ST_SKIP:
                begin
                    state_r <= btc_pkg::BTC_ST_IDLE;
                end
                btc_pkg::BTC_ST_CALL:
                begin
                    state_r <= btc_pkg::BTC_ST_IDLE;
                end
                default:
                begin
                    state_r <= btc_pkg::BTC_ST_IDLE;
                end
            endcase
        end
    end

    // prefetched word is killed in the extra cycle, both for skip and call
    // discard and nop
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            discard_r <= 1'b0;
        end
        else
        begin
            discard_r <= accept && (is_call || skip_take);
        end
    end

    // program counter load in the second call cycle
    // target registered at accept
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pc_load_r <= 1'b0;
            pc_target_r <= '0;
        end
        else
        begin
            pc_load_r <= accept && is_call;
            if (accept && is_call)
            begin
                pc_target_r <= target_nxt;
            end
        end
    end

    // stack pointer; overflow wraps, nothing guards it
    // post-increment after push
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stack_ptr_r <= SP_W'(`BTC_SP_RST);
        end
        else if (accept && is_call)
        begin
            stack_ptr_r <= stack_ptr_r + SP_W'(1);
        end
    end

    // =================================================================
    // return address storage
    // write at current pointer
    btc_stack_mem #(
        .DEPTH(STACK_DEPTH),
        .AW(SP_W)
    ) u_stack (
        .clock(clock),
        .wr_en(accept && is_call),
        .wr_addr(stack_ptr_r),
        .wr_data(ret_addr),
        .rd_addr(stack_ptr_r - SP_W'(1)),
        .rd_data(stack_top)
    );

    // =================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_skip_clear_zero: assert property (
        accept && instr_op == btc_pkg::BTC_OP_SKIP_CLR && !bit_val |=> discard_r && !instr_ready)
        else $error("skip-if-clear did not skip on zero bit");
    a_skip_clear_one: assert property (
        accept && instr_op == btc_pkg::BTC_OP_SKIP_CLR && bit_val |=> !discard_r && instr_ready)
        else $error("skip-if-clear skipped on one bit");
    a_skip_set_bit: assert property (
        accept && instr_op == btc_pkg::BTC_OP_SKIP_SET |=> discard_r == $past(bit_val))
        else $error("skip-if-set decision wrong");
    a_skip_two_cycles: assert property (
        accept && is_skip_op && skip_take |=> !instr_ready ##1 instr_ready && !discard_r)
        else $error("taken skip not exactly two cycles");
    a_call_two_cycles: assert property (
        accept && is_call |=> pc_load_r && !instr_ready ##1 instr_ready && !pc_load_r)
        else $error("call not exactly two cycles");
    a_call_ret_push: assert property (
        accept && is_call |-> ##2 stack_top == $past(pc, 2) + `BTC_PC_INC)
        else $error("pushed return address wrong");
    a_call_imm_target: assert property (
        accept && instr_op == btc_pkg::BTC_OP_CALL |=>
        pc_target_r == {$past(call_page_buffer[`BTC_PC_HI_MSB:0]), $past(call_addr)})
        else $error("immediate call target wrong");
    a_call_ind_target: assert property (
        accept && instr_op == btc_pkg::BTC_OP_ICALL |=>
        pc_target_r == {$past(table_high_pointer[`BTC_PC_HI_MSB:0]), $past(accumulator)})
        else $error("indirect call target wrong");
    a_stack_ptr_inc: assert property (
        accept && is_call |=> stack_ptr_r == $past(stack_ptr_r) + SP_W'(1))
        else $error("stack pointer not incremented");
    a_bit_select_seven: assert property (
        accept && instr_op == btc_pkg::BTC_OP_SKIP_SET && bit_sel == `BTC_BIT_W'(`BTC_DATA_W - 1) |=>
        discard_r == $past(reg_rdata[`BTC_DATA_W-1]))
        else $error("bit select 7 misread");
    a_flags_untouched: assert property (
        $rose(pc_load_r) |-> !status_we && $past(accept))
        else $error("flags written or stray pc load");

    c_skip_clear: cover property (accept && instr_op == btc_pkg::BTC_OP_SKIP_CLR && !bit_val);
    c_skip_set: cover property (accept && instr_op == btc_pkg::BTC_OP_SKIP_SET && bit_val);
    c_call_imm: cover property (accept && instr_op == btc_pkg::BTC_OP_CALL);
    c_call_ind: cover property (accept && instr_op == btc_pkg::BTC_OP_ICALL ##2 accept && is_call);

endmodule : btc_exec
`default_nettype wire

// >>> src/btc_defs.svh
`ifndef BTC_DEFS_SVH
`define BTC_DEFS_SVH

// =====================================================================
// operand field widths
`define BTC_REG_W 7
`define BTC_BIT_W 3
`define BTC_ADR_W 8
`define BTC_PC_W 11
`define BTC_DATA_W 8

// =====================================================================
// program counter split: high page bits sit above the low byte
`define BTC_PC_LO_MSB 7
`define BTC_PC_HI_W 3
`define BTC_PC_HI_MSB 2

// =====================================================================
// reset and increment values
`define BTC_SP_RST 0
`define BTC_PC_INC 11'h001
`define BTC_ZERO_BYTE 8'h00

`endif

// >>> src/btc_pkg.sv
// =====================================================================
// shared types of the bit test / call execution block
package btc_pkg;

    // decoded instruction class handed over by the core decoder
    typedef enum logic [2:0] {
        BTC_OP_OTHER = 3'h0,
        BTC_OP_SKIP_CLR = 3'h1,
        BTC_OP_SKIP_SET = 3'h2,
        BTC_OP_CALL = 3'h3,
        BTC_OP_ICALL = 3'h4
    } btc_op_t;

    // execution state, gray coded along idle -> extra cycle -> idle
    typedef enum logic [1:0] {
        BTC_ST_IDLE = 2'h0,
        BTC_ST_SKIP = 2'h1,
        BTC_ST_CALL = 2'h2
    } btc_state_t;

endpackage : btc_pkg

// >>> src/btc_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "btc_defs.svh"

// =====================================================================
// return address stack storage, registered read port
module btc_stack_mem #(
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [`BTC_PC_W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [`BTC_PC_W-1:0] rd_data
);

    logic [`BTC_PC_W-1:0] mem [DEPTH];

    // write port, no reset so it maps onto plain storage
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data from a register, one cycle after the address
    always_ff @(posedge clock)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule : btc_stack_mem
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "btc_defs.svh"

// =====================================================================
// self-checking bench: driver notes expectations, monitor compares
module tb_top;
    typedef struct packed {
        logic fire;
        logic call;
        logic [`BTC_PC_W-1:0] tgt;
        logic [2:0] sp;
        logic [`BTC_PC_W-1:0] ret;
    } btc_exp_t;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic instr_valid = 1'b0;
    btc_pkg::btc_op_t instr_op = btc_pkg::BTC_OP_OTHER;
    logic [6:0] reg_operand = 7'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] call_addr = 8'h00, reg_rdata = 8'h00, page = 8'h00, thp = 8'h00, acc = 8'h00;
    logic [10:0] pc = 11'h000;
    logic instr_ready, discard_r, pc_load_r, status_we;
    logic [6:0] reg_raddr;
    logic [10:0] pc_target_r, stack_top, top_exp, tgt_m;
    logic [2:0] stack_ptr_r, sp_m;
    logic took = 1'b0, top_due = 1'b0;
    btc_exp_t exp_q[$];
    btc_exp_t cur;
    int miscompares = 0, num_checks = 0;

    btc_exec dut (.clock(clock), .nrst(nrst), .instr_valid(instr_valid), .instr_op(instr_op),
        .reg_operand(reg_operand), .bit_sel(bit_sel), .call_addr(call_addr), .reg_rdata(reg_rdata),
        .pc(pc), .call_page_buffer(page), .table_high_pointer(thp), .accumulator(acc),
        .instr_ready(instr_ready), .reg_raddr(reg_raddr), .discard_r(discard_r), .pc_load_r(pc_load_r),
        .pc_target_r(pc_target_r), .stack_ptr_r(stack_ptr_r), .stack_top(stack_top), .status_we(status_we));

    // =====================================================================
    // 20 MHz clock
    initial
    begin
        forever #25 clock = ~clock;
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv)
        begin
            $display("ERROR %s expected %h seen %h", name, expv, seen);
            miscompares++;
        end
    endtask : chk

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // one instruction; while busy a call is offered and must be ignored
    task issue(input int op, input logic [6:0] r, input logic [2:0] b, input logic [7:0] d,
        input logic [10:0] p, input logic [7:0] pg, input logic [7:0] th, input logic [7:0] ac,
        input logic [7:0] ad);
        btc_exp_t e;
        while (instr_ready !== 1'b1)
        begin
            instr_op = btc_pkg::BTC_OP_CALL; // refused request
            @(posedge clock);
            #1;
        end
        instr_valid = 1'b1;
        instr_op = btc_pkg::btc_op_t'(op);
        reg_operand = r;
        bit_sel = b;
        reg_rdata = d;
        pc = p;
        page = pg;
        thp = th;
        acc = ac;
        call_addr = ad;
        e.call = (op == 3 || op == 4);
        e.fire = e.call || (op == 1 && !d[b]) || (op == 2 && d[b]);
        if (e.call)
        begin
            tgt_m = (op == 3) ? {pg[2:0], ad} : {th[2:0], ac};
            sp_m = sp_m + 3'h1;
        end
        e.tgt = tgt_m;
        e.sp = sp_m;
        e.ret = p + 11'h001;
        exp_q.push_back(e);
        @(posedge clock);
        #1;
    endtask : issue

    // =====================================================================
    // monitor: answer is due one cycle after each accepted instruction
    always @(negedge clock)
    begin
        if (nrst === 1'b1)
        begin
            chk("status_we", status_we, 0);
            chk("reg_raddr", reg_raddr, reg_operand);
            if (top_due)
                chk("stack_top", stack_top, top_exp);
            top_due = 1'b0;
            if (took)
            begin
                chk("answer count", exp_q.size() > 0, 1);
                cur = exp_q.pop_front();
                chk("discard_r", discard_r, cur.fire);
                chk("pc_load_r", pc_load_r, cur.call);
                chk("instr_ready", instr_ready, !cur.fire);
                chk("stack_ptr_r", stack_ptr_r, cur.sp);
                chk("pc_target_r", pc_target_r, cur.tgt);
                top_exp = cur.ret;
                top_due = cur.call;
            end
            else
                chk("idle pulses", {discard_r, pc_load_r}, 0);
            took = instr_valid && instr_ready;
        end
    end

    // watchdog, far beyond the expected run length
    initial
    begin
        #(50 * 20000);
        miscompares++;
        final_report();
    end

    // =====================================================================
    // main sequence
    initial
    begin
        void'($urandom(32'h68ED2E54));
        sp_m = 3'h0;
        tgt_m = 11'h000;
        repeat (6) @(posedge clock);
        #1;
        nrst = 1'b1;
        chk("ready at reset", {instr_ready, discard_r, pc_load_r, stack_ptr_r}, 6'h20);
        // data-sheet style cases; upper page bits must be ignored, return wraps
        issue(1, 7'h7F, 3'h2, 8'h5A, 11'h0A0, 8'h00, 8'h00, 8'h00, 8'h00);
        issue(2, 7'h00, 3'h3, 8'h5A, 11'h0A1, 8'h00, 8'h00, 8'h00, 8'h00);
        issue(3, 7'h10, 3'h0, 8'h00, 11'h0A0, 8'hFD, 8'h00, 8'h00, 8'hFF);
        issue(4, 7'h10, 3'h0, 8'h00, 11'h7FF, 8'h00, 8'hFA, 8'h34, 8'h00);
        // every bit in both polarities, untaken ones back to back
        for (int i = 0; i < 16; i++)
            issue(1 + i / 8, 7'(i * 9), 3'(i), 8'hA5, 11'(i), 8'h00, 8'h00, 8'h00, 8'h00);
        // random mix of all classes, stack pointer wraps
        repeat (300)
            issue($urandom_range(0, 4), 7'($urandom), 3'($urandom), 8'($urandom), 11'($urandom),
                8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
        instr_valid = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk("queue empty", exp_q.size(), 0);
        // reset in the busy cycle of a call
        issue(3, 7'h01, 3'h1, 8'h00, 11'h123, 8'h06, 8'h00, 8'h00, 8'h44);
        nrst = 1'b0;
        instr_valid = 1'b0;
        exp_q.delete();
        took = 1'b0;
        #100;
        chk("state in reset", {instr_ready, discard_r, pc_load_r, stack_ptr_r}, 6'h20);
        sp_m = 3'h0;
        tgt_m = 11'h000;
        @(posedge clock);
        #1;
        nrst = 1'b1;
        issue(4, 7'h02, 3'h2, 8'h00, 11'h010, 8'h00, 8'h03, 8'h9C, 8'h00);
        instr_valid = 1'b0;
        repeat (4) @(posedge clock);
        chk("queue empty", exp_q.size(), 0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
